// File: rtl/tfad_pkg.sv
package tfad_pkg;

  // mapping-select field
  localparam int INDEX_W = 6;
  localparam logic [5:0] INDEX_RESET = 6'h00;
  localparam logic [5:0] INDEX_MEM = 6'h00;
  localparam logic [5:0] INDEX_CONTIG = 6'h01;
  localparam logic [5:0] INDEX_PRIMARY = 6'h02;
  localparam logic [5:0] INDEX_SECONDARY = 6'h03;

  // host address layout
  localparam int ADDR_W = 11;
  localparam int A_BYTE_WIN = 10;

  // base compares on a9..a4 and low compares on a2..a0 for the fixed i/o maps
  localparam logic [5:0] PRI_TASK_BASE = 6'h1f;
  localparam logic [5:0] PRI_ALT_BASE = 6'h3f;
  localparam logic [5:0] SEC_TASK_BASE = 6'h17;
  localparam logic [5:0] SEC_ALT_BASE = 6'h37;
  localparam logic [2:0] ALT_LOW3 = 3'h6;
  localparam logic [2:0] DRV_LOW3 = 3'h7;

  // task file offsets
  localparam logic [3:0] OFF_DATA = 4'h0;
  localparam logic [3:0] OFF_ERR_FEAT = 4'h1;
  localparam logic [3:0] OFF_STAT_CMD = 4'h7;
  localparam logic [3:0] OFF_DUP_EVEN = 4'h8;
  localparam logic [3:0] OFF_DUP_ODD = 4'h9;
  localparam logic [3:0] OFF_DUP_ERR = 4'hd;
  localparam logic [3:0] OFF_ALT_CTL = 4'he;
  localparam logic [3:0] OFF_DRV_ADDR = 4'hf;

  // register reached by an access
  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_DATA = 4'h1,
    TGT_ERR_FEAT = 4'h2,
    TGT_SEC_COUNT = 4'h3,
    TGT_SEC_NUM = 4'h4,
    TGT_CYL_LOW = 4'h5,
    TGT_CYL_HIGH = 4'h6,
    TGT_DRV_HEAD = 4'h7,
    TGT_STAT_CMD = 4'h8,
    TGT_ALT_CTL = 4'h9,
    TGT_DRV_ADDR = 4'ha,
    TGT_EVEN_DATA = 4'hb,
    TGT_ODD_DATA = 4'hc
  } tfad_tgt_t;

  // byte lanes of a data access
  typedef enum logic [1:0] {
    LANE_WORD = 2'h0,
    LANE_EVEN = 2'h1,
    LANE_ODD = 2'h2,
    LANE_NONE = 2'h3
  } tfad_lane_t;

  // active mapping
  typedef enum logic [2:0] {
    MODE_MEM = 3'h0,
    MODE_CONTIG = 3'h1,
    MODE_PRIMARY = 3'h2,
    MODE_SECONDARY = 3'h3,
    MODE_TRUE_IDE = 3'h4,
    MODE_UNMAPPED = 3'h7
  } tfad_mode_t;

endpackage

// File: rtl/tfad_decode.sv
// Functional notes
// - task file decode follows one of four mappings chosen by the index field.
// - output enable held low at power-up selects the True IDE mapping instead.
// - reads and writes at one offset reach different registers (1, 7, E, F).
// - memory mode: A10 low uses A3..A0; A10 high decodes A0 only.
// - offsets 9 and D duplicate odd data and error/feature in mem/contig.
// - contiguous i/o: register space low, A3..A0 pick the sixteen offsets.
// - primary i/o answers only when A9..A4 is 1Fh or 3Fh and A3 is 0.
// - secondary i/o: 17h task file, 37h with 110/111 alt status/drive addr.
// - index field returns to zero on power-on, hard and soft reset.
// - primary map spans 1F0h..1F7h plus 3F6h..3F7h.
// - True IDE: enables high/low pick task file, reversed pick alt/drive.
module tfad_decode (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host address and select
  input wire logic [10:0] host_addr,
  input wire logic reg_space_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  // host strobes
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  // mapping-select field and card resets
  input wire logic index_wr,
  input wire logic [5:0] index_wdata,
  input wire logic hard_reset,
  input wire logic soft_reset,
  // decode result
  output logic [3:0] tgt_sel,
  output logic [1:0] lane_sel,
  output logic access_rd,
  output logic access_wr,
  output logic access_miss,
  // mapping state
  output logic [2:0] mode_out,
  output logic [5:0] index_out,
  output logic true_ide_out
);

  // offset within the sixteen-register layout to its target
  function automatic tfad_pkg::tfad_tgt_t off_to_tgt(
    input logic [3:0] off,
    input logic wr
  );
    tfad_pkg::tfad_tgt_t t;
    t = tfad_pkg::TGT_NONE;
    case (off)
      4'h0: t = tfad_pkg::TGT_DATA;
      4'h1: t = tfad_pkg::TGT_ERR_FEAT;
      4'h2: t = tfad_pkg::TGT_SEC_COUNT;
      4'h3: t = tfad_pkg::TGT_SEC_NUM;
      4'h4: t = tfad_pkg::TGT_CYL_LOW;
      4'h5: t = tfad_pkg::TGT_CYL_HIGH;
      4'h6: t = tfad_pkg::TGT_DRV_HEAD;
      4'h7: t = tfad_pkg::TGT_STAT_CMD;
      4'h8: t = tfad_pkg::TGT_EVEN_DATA;
      4'h9: t = tfad_pkg::TGT_ODD_DATA;
      4'hd: t = tfad_pkg::TGT_ERR_FEAT;
      4'he: t = tfad_pkg::TGT_ALT_CTL;
      4'hf: t = wr ? tfad_pkg::TGT_NONE : tfad_pkg::TGT_DRV_ADDR;
      default: t = tfad_pkg::TGT_NONE;
    endcase
    return t;
  endfunction

  // byte lanes from the two card enables and a0
  function automatic tfad_pkg::tfad_lane_t lane_of(
    input logic ce_lo_n,
    input logic ce_hi_n,
    input logic a0
  );
    tfad_pkg::tfad_lane_t l;
    l = tfad_pkg::LANE_NONE;
    if (!ce_lo_n && !ce_hi_n) begin
      l = tfad_pkg::LANE_WORD;
    end else if (!ce_lo_n) begin
      l = a0 ? tfad_pkg::LANE_ODD : tfad_pkg::LANE_EVEN;
    end else if (!ce_hi_n) begin
      l = tfad_pkg::LANE_ODD;
    end
    return l;
  endfunction

  // mapping state
  logic [5:0] index_r;
  logic [5:0] index_nxt;
  logic strap_taken_r;
  logic strap_taken_nxt;
  logic true_ide_r;
  logic true_ide_nxt;

  // decode registers
  tfad_pkg::tfad_tgt_t tgt_r;
  tfad_pkg::tfad_tgt_t tgt_nxt;
  tfad_pkg::tfad_lane_t lane_r;
  tfad_pkg::tfad_lane_t lane_nxt;
  tfad_pkg::tfad_mode_t mode_r;
  tfad_pkg::tfad_mode_t mode_nxt;
  logic rd_r;
  logic rd_nxt;
  logic wr_r;
  logic wr_nxt;
  logic miss_r;
  logic miss_nxt;

  // combinational decode terms
  logic rd_cyc;
  logic wr_cyc;
  logic any_ce;
  logic [5:0] a9_4;
  logic [2:0] a2_0;

  // mapping state next values
  always_comb begin
    index_nxt = index_r;
    strap_taken_nxt = 1'b1;
    true_ide_nxt = true_ide_r;
    if (!strap_taken_r) begin
      true_ide_nxt = ~mem_oe_n;
    end
    if (hard_reset || soft_reset) begin
      index_nxt = tfad_pkg::INDEX_RESET;
    end else if (index_wr) begin
      index_nxt = index_wdata;
    end
  end

  // mapping state registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      index_r <= tfad_pkg::INDEX_RESET;
      strap_taken_r <= 1'b0;
      true_ide_r <= 1'b0;
    end else begin
      index_r <= index_nxt;
      strap_taken_r <= strap_taken_nxt;
      true_ide_r <= true_ide_nxt;
    end
  end

  // address fields
  assign a9_4 = host_addr[9:4];
  assign a2_0 = host_addr[2:0];
  assign any_ce = ~(card_enable_low_n & card_enable_high_n);

  // active mapping and strobes of that mapping
  always_comb begin
    mode_nxt = tfad_pkg::MODE_UNMAPPED;
    if (true_ide_r) begin
      mode_nxt = tfad_pkg::MODE_TRUE_IDE;
    end else begin
      case (index_r)
        tfad_pkg::INDEX_MEM: mode_nxt = tfad_pkg::MODE_MEM;
        tfad_pkg::INDEX_CONTIG: mode_nxt = tfad_pkg::MODE_CONTIG;
        tfad_pkg::INDEX_PRIMARY: mode_nxt = tfad_pkg::MODE_PRIMARY;
        tfad_pkg::INDEX_SECONDARY: mode_nxt = tfad_pkg::MODE_SECONDARY;
        default: mode_nxt = tfad_pkg::MODE_UNMAPPED;
      endcase
    end
    if (mode_nxt == tfad_pkg::MODE_MEM) begin
      rd_cyc = reg_space_n && !mem_oe_n;
      wr_cyc = reg_space_n && !mem_we_n;
    end else if (mode_nxt == tfad_pkg::MODE_TRUE_IDE) begin
      rd_cyc = !io_rd_n;
      wr_cyc = !io_wr_n;
    end else begin
      rd_cyc = !reg_space_n && !io_rd_n;
      wr_cyc = !reg_space_n && !io_wr_n;
    end
  end

  // target register of the current host cycle
  always_comb begin
    tgt_nxt = tfad_pkg::TGT_NONE;
    lane_nxt = tfad_pkg::LANE_NONE;
    case (mode_nxt)
      tfad_pkg::MODE_MEM: begin
        if (host_addr[tfad_pkg::A_BYTE_WIN]) begin
          tgt_nxt = host_addr[0] ? tfad_pkg::TGT_ODD_DATA
                                 : tfad_pkg::TGT_EVEN_DATA;
        end else begin
          tgt_nxt = off_to_tgt(host_addr[3:0], wr_cyc);
        end
      end
      tfad_pkg::MODE_CONTIG: begin
        tgt_nxt = off_to_tgt(host_addr[3:0], wr_cyc);
      end
      tfad_pkg::MODE_PRIMARY: begin
        if (a9_4 == tfad_pkg::PRI_TASK_BASE && !host_addr[3]) begin
          tgt_nxt = off_to_tgt({1'b0, a2_0}, wr_cyc);
        end else if (a9_4 == tfad_pkg::PRI_ALT_BASE && !host_addr[3]) begin
          if (a2_0 == tfad_pkg::ALT_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_ALT_CTL, wr_cyc);
          end else if (a2_0 == tfad_pkg::DRV_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_DRV_ADDR, wr_cyc);
          end
        end
      end
      tfad_pkg::MODE_SECONDARY: begin
        if (a9_4 == tfad_pkg::SEC_TASK_BASE && !host_addr[3]) begin
          tgt_nxt = off_to_tgt({1'b0, a2_0}, wr_cyc);
        end else if (a9_4 == tfad_pkg::SEC_ALT_BASE && !host_addr[3]) begin
          if (a2_0 == tfad_pkg::ALT_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_ALT_CTL, wr_cyc);
          end else if (a2_0 == tfad_pkg::DRV_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_DRV_ADDR, wr_cyc);
          end
        end
      end
      tfad_pkg::MODE_TRUE_IDE: begin
        if (card_enable_high_n && !card_enable_low_n) begin
          tgt_nxt = off_to_tgt({1'b0, a2_0}, wr_cyc);
        end else if (!card_enable_high_n && card_enable_low_n) begin
          if (a2_0 == tfad_pkg::ALT_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_ALT_CTL, wr_cyc);
          end else if (a2_0 == tfad_pkg::DRV_LOW3) begin
            tgt_nxt = off_to_tgt(tfad_pkg::OFF_DRV_ADDR, wr_cyc);
          end
        end
      end
      default: begin
        tgt_nxt = tfad_pkg::TGT_NONE;
      end
    endcase
    // no cycle, both strobes at once, or no enable: nothing is reached
    if (!(rd_cyc ^ wr_cyc) || !any_ce) begin
      tgt_nxt = tfad_pkg::TGT_NONE;
    end
    if (tgt_nxt != tfad_pkg::TGT_NONE) begin
      if (mode_nxt == tfad_pkg::MODE_TRUE_IDE) begin
        lane_nxt = (tgt_nxt == tfad_pkg::TGT_DATA) ? tfad_pkg::LANE_WORD
                                                  : tfad_pkg::LANE_EVEN;
      end else begin
        lane_nxt = lane_of(card_enable_low_n, card_enable_high_n,
                           host_addr[0]);
      end
    end
    rd_nxt = rd_cyc && !wr_cyc && (tgt_nxt != tfad_pkg::TGT_NONE);
    wr_nxt = wr_cyc && !rd_cyc && (tgt_nxt != tfad_pkg::TGT_NONE);
    miss_nxt = (rd_cyc ^ wr_cyc) && any_ce &&
               (tgt_nxt == tfad_pkg::TGT_NONE);
  end

  // decode registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      tgt_r <= tfad_pkg::TGT_NONE;
      lane_r <= tfad_pkg::LANE_NONE;
      mode_r <= tfad_pkg::MODE_MEM;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      miss_r <= 1'b0;
    end else begin
      tgt_r <= tgt_nxt;
      lane_r <= lane_nxt;
      mode_r <= mode_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      miss_r <= miss_nxt;
    end
  end

  // outputs straight from flip-flops
  assign tgt_sel = tgt_r;
  assign lane_sel = lane_r;
  assign access_rd = rd_r;
  assign access_wr = wr_r;
  assign access_miss = miss_r;
  assign mode_out = mode_r;
  assign index_out = index_r;
  assign true_ide_out = true_ide_r;

endmodule

// File: bench/tfad_host.sv
// host controller model: drives one strobe cycle at a time
module tfad_host (
  // clock
  input wire logic ref_clk,
  // host pins
  output logic [10:0] host_addr,
  output logic reg_space_n,
  output logic card_enable_low_n,
  output logic card_enable_high_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  output logic io_rd_n,
  output logic io_wr_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // released bus: address shows the inverse of its last value
  task automatic idle();
    {mem_oe_n, mem_we_n, io_rd_n, io_wr_n} = 4'hf;
    {card_enable_low_n, card_enable_high_n} = 2'h3;
    host_addr = ~host_addr;
    reg_space_n = ~reg_space_n;
  endtask
  // output enable level held through reset picks the mapping
  task automatic strap(input logic v);
    mem_oe_n = v;
  endtask
  // drive after an edge, hold across the next edge, then release
  task automatic cyc(input logic rd, io, input logic [10:0] a,
                     input logic [1:0] ce);
    @(posedge ref_clk);
    #1;
    host_addr = a;
    reg_space_n = ~io;
    {card_enable_high_n, card_enable_low_n} = ce;
    {mem_oe_n, mem_we_n} = io ? 2'h3 : {~rd, rd};
    {io_rd_n, io_wr_n} = io ? {~rd, rd} : 2'h3;
    @(posedge ref_clk);
    #1;
    idle();
  endtask
  // idle pins at time zero
  initial begin
    host_addr = 11'h000;
    reg_space_n = 1'b1;
    idle();
  end
endmodule

// File: bench/tfad_decode_asserts.sv
module tfad_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // host side
  input wire logic [10:0] host_addr,
  input wire logic reg_space_n,
  input wire logic card_enable_low_n,
  input wire logic card_enable_high_n,
  input wire logic mem_oe_n,
  input wire logic mem_we_n,
  input wire logic io_rd_n,
  input wire logic io_wr_n,
  // mapping field
  input wire logic index_wr,
  input wire logic [5:0] index_wdata,
  input wire logic hard_reset,
  input wire logic soft_reset,
  // decode result
  input wire logic [3:0] tgt_sel,
  input wire logic access_miss,
  input wire logic [2:0] mode_out,
  input wire logic [5:0] index_out,
  input wire logic true_ide_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // single-strobe cycles with the low enable only
  wire logic lo = !card_enable_low_n && card_enable_high_n;
  wire logic m_rd = !mem_oe_n && mem_we_n && io_rd_n && reg_space_n && lo;
  wire logic m_wr = mem_oe_n && !mem_we_n && io_wr_n && reg_space_n && lo;
  wire logic i_rd = !io_rd_n && io_wr_n && mem_oe_n && !reg_space_n && lo;
  a_idle_none: assert property (&{mem_oe_n, mem_we_n, io_rd_n, io_wr_n}
    |=> tgt_sel == tfad_pkg::TGT_NONE) else $error("target without strobe");
  a_index_load: assert property (index_wr && !hard_reset && !soft_reset
    |=> index_out == $past(index_wdata)) else $error("index not loaded");
  a_index_clear: assert property (hard_reset || soft_reset
    |=> index_out == 6'h00) else $error("index not cleared");
  a_mode_follow: assert property (index_out == 6'h02 && !true_ide_out
    |=> mode_out == tfad_pkg::MODE_PRIMARY) else $error("mode not primary");
  a_mem_byte: assert property (mode_out == 3'h0 && m_rd && host_addr[10]
    |=> tgt_sel == ($past(host_addr[0]) ? tfad_pkg::TGT_ODD_DATA :
    tfad_pkg::TGT_EVEN_DATA)) else $error("byte window wrong");
  a_drv_wr_miss: assert property (mode_out == 3'h0 && m_wr
    && !host_addr[10] && host_addr[3:0] == 4'hf
    |=> tgt_sel == 4'h0 && access_miss) else $error("reserved write taken");
  a_pri_range: assert property (mode_out == tfad_pkg::MODE_PRIMARY
    && host_addr[9:4] != 6'h1f && host_addr[9:4] != 6'h3f
    |=> tgt_sel == 4'h0) else $error("primary answered off range");
  a_sec_alt: assert property (mode_out == 3'h3 && i_rd
    && host_addr[9:0] == 10'h376
    |=> tgt_sel == tfad_pkg::TGT_ALT_CTL) else $error("secondary alt wrong");
  c_ide: cover property (mode_out == tfad_pkg::MODE_TRUE_IDE);
  c_miss: cover property (access_miss);
  c_alt: cover property (tgt_sel == tfad_pkg::TGT_ALT_CTL);
endmodule
bind tfad_decode tfad_chk i_tfad_chk (.*);

// File: bench/tb_task_file_address_decode.sv
module tb_task_file_address_decode;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic reset_n, index_wr, hard_reset, soft_reset;
  logic [5:0] index_wdata, index_out;
  logic [10:0] host_addr;
  logic reg_space_n, card_enable_low_n, card_enable_high_n;
  logic mem_oe_n, mem_we_n, io_rd_n, io_wr_n;
  logic [3:0] tgt_sel;
  logic [1:0] lane_sel;
  logic access_rd, access_wr, access_miss, true_ide_out;
  logic [2:0] mode_out;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic ide_on = 1'b0;
  tfad_decode i_tfad_decode (.*);
  tfad_host i_tfad_host (.*);
  // clock and hang guard
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      $display("ERROR at %0t: timeout", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tc(input logic rd, io, input logic [10:0] a,
                    input logic [3:0] exp);
    logic [1:0] el;
    logic hit;
    hit = (exp != tfad_pkg::TGT_NONE);
    el = a[0] ? tfad_pkg::LANE_ODD : tfad_pkg::LANE_EVEN;
    if (ide_on) begin
      el = (exp == tfad_pkg::TGT_DATA) ? tfad_pkg::LANE_WORD
                                       : tfad_pkg::LANE_EVEN;
    end
    if (!hit) begin
      el = tfad_pkg::LANE_NONE;
    end
    i_tfad_host.cyc(rd, io, a, 2'b10);
    chk({2'h0, tgt_sel}, {2'h0, exp});
    chk({4'h0, lane_sel}, {4'h0, el});
    chk({4'h0, access_rd, access_wr}, {4'h0, rd && hit, !rd && hit});
  endtask
  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    #1;
    reset_n = 1'b0;
    i_tfad_host.strap(strap);
    repeat (2) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    i_tfad_host.strap(1'b1);
    chk(index_out, 6'h00);
  endtask
  task automatic set_idx(input logic [5:0] v, input logic [2:0] m);
    @(posedge ref_clk);
    #1;
    {index_wr, index_wdata} = {1'b1, v};
    @(posedge ref_clk);
    #1;
    index_wr = 1'b0;
    @(posedge ref_clk);
    #1;
    chk({3'h0, mode_out}, {3'h0, m});
  endtask
  task automatic s_mem();
    tc(1, 0, 11'h001, tfad_pkg::TGT_ERR_FEAT);
    tc(0, 0, 11'h3f7, tfad_pkg::TGT_STAT_CMD);
    tc(0, 0, 11'h00f, tfad_pkg::TGT_NONE);
    tc(1, 0, 11'h00f, tfad_pkg::TGT_DRV_ADDR);
    tc(1, 0, 11'h008, tfad_pkg::TGT_EVEN_DATA);
    tc(1, 0, 11'h00d, tfad_pkg::TGT_ERR_FEAT);
    tc(1, 0, 11'h00b, tfad_pkg::TGT_NONE);
    tc(1, 0, 11'h7f1, tfad_pkg::TGT_ODD_DATA);
    // both enables low give a word, the high enable alone the odd byte
    i_tfad_host.cyc(1'b1, 1'b0, 11'h000, 2'b00);
    chk({4'h0, lane_sel}, {4'h0, tfad_pkg::LANE_WORD});
    i_tfad_host.cyc(1'b1, 1'b0, 11'h000, 2'b01);
    chk({4'h0, lane_sel}, {4'h0, tfad_pkg::LANE_ODD});
    chk({2'h0, tgt_sel}, {2'h0, tfad_pkg::TGT_DATA});
  endtask
  task automatic s_io();
    set_idx(6'h01, tfad_pkg::MODE_CONTIG);
    tc(1, 1, 11'h7fe, tfad_pkg::TGT_ALT_CTL);
    tc(0, 1, 11'h0e9, tfad_pkg::TGT_ODD_DATA);
    tc(1, 0, 11'h007, tfad_pkg::TGT_NONE);
    set_idx(6'h02, tfad_pkg::MODE_PRIMARY);
    tc(0, 1, 11'h5f2, tfad_pkg::TGT_SEC_COUNT);
    tc(1, 1, 11'h1fa, tfad_pkg::TGT_NONE);
    tc(1, 1, 11'h3f7, tfad_pkg::TGT_DRV_ADDR);
    tc(1, 1, 11'h172, tfad_pkg::TGT_NONE);
    set_idx(6'h03, tfad_pkg::MODE_SECONDARY);
    tc(1, 1, 11'h177, tfad_pkg::TGT_STAT_CMD);
    tc(1, 1, 11'h376, tfad_pkg::TGT_ALT_CTL);
    tc(0, 1, 11'h377, tfad_pkg::TGT_NONE);
    set_idx(6'h04, tfad_pkg::MODE_UNMAPPED);
    tc(1, 1, 11'h1f0, tfad_pkg::TGT_NONE);
  endtask
  task automatic s_clear();
    {soft_reset, index_wr, index_wdata} = {2'h3, 6'h02};
    @(posedge ref_clk);
    #1;
    {soft_reset, index_wr} = 2'h0;
    chk(index_out, 6'h00);
    set_idx(6'h01, tfad_pkg::MODE_CONTIG);
    hard_reset = 1'b1;
    @(posedge ref_clk);
    #1;
    hard_reset = 1'b0;
    @(posedge ref_clk);
    #1;
    chk({3'h0, mode_out}, {3'h0, tfad_pkg::MODE_MEM});
  endtask
  task automatic s_ide();
    do_reset(1'b0);
    ide_on = 1'b1;
    chk({3'h0, mode_out}, {3'h0, tfad_pkg::MODE_TRUE_IDE});
    chk({5'h00, true_ide_out}, 6'h01);
    tc(1, 1, 11'h003, tfad_pkg::TGT_SEC_NUM);
    tc(1, 1, 11'h006, tfad_pkg::TGT_DRV_HEAD);
    i_tfad_host.cyc(1'b0, 1'b1, 11'h006, 2'b01);
    chk({2'h0, tgt_sel}, {2'h0, tfad_pkg::TGT_ALT_CTL});
    chk({4'h0, lane_sel}, {4'h0, tfad_pkg::LANE_EVEN});
    chk({4'h0, access_rd, access_wr}, 6'h01);
  endtask
  // main sequence
  initial begin
    {reset_n, index_wr, hard_reset, soft_reset} = 4'h0;
    index_wdata = 6'h00;
    do_reset(1'b1);
    s_mem();
    s_io();
    s_clear();
    s_ide();
    end_sim();
  end
endmodule
